//--- logic/async_nor_flash_timing_engine.sv
// Strobe timing engine for asynchronous NOR flash accesses on eight chip selects
`timescale 1ns/10ps
`default_nettype none
module async_nor_flash_timing_engine #(
   parameter int FIFO_WIDTH = nor_timing_pkg::DATA_W,
   parameter int FIFO_DEPTH = nor_timing_pkg::FIFO_DEPTH
) (
   input wire logic mclk_in,
   input wire logic arst_n_in,
   input wire logic req_valid_in,
   input wire nor_timing_pkg::access_req_t req_in,
   output logic req_ready_out,
   input wire nor_timing_pkg::select_cfg_t cfg_in [nor_timing_pkg::NUM_SELECTS],
   input wire logic [nor_timing_pkg::NUM_WAITS-1:0] wait_in,
   output logic [nor_timing_pkg::NUM_SELECTS-1:0] cs_n_out,
   output logic addr_valid_n_out,
   output logic read_strobe_n_out,
   output logic write_strobe_n_out,
   output logic [1:0] byte_en_n_out,
   output logic [nor_timing_pkg::ADDR_W-1:0] addr_out,
   output logic addr_drive_out,
   output logic [nor_timing_pkg::DATA_W-1:0] data_out,
   output logic data_oe_out,
   input wire logic [nor_timing_pkg::DATA_W-1:0] data_in,
   output logic ext_clk_out,
   output logic busy_out,
   output logic rd_valid_out,
   output logic [FIFO_WIDTH-1:0] rd_data_out,
   input wire logic rd_ready_in
);
   localparam int CW = nor_timing_pkg::CNT_W;
   // ==========================================================================
   // Reset release
   logic rst_meta_r;
   logic rst_n;
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end
   // ==========================================================================
   // Edge placement
   function automatic logic [CW-1:0] scale(input logic [nor_timing_pkg::TIME_W-1:0] t, input logic x2);
      scale = x2 ? CW'({t, 1'b0}) : CW'(t);
   endfunction
   // Scaled time plus the cycles that line the edge up with the external clock
   function automatic logic [CW-1:0] place(input logic [nor_timing_pkg::TIME_W-1:0] t,
                                           input nor_timing_pkg::select_cfg_t c);
      logic [CW-1:0] diff;
      logic [CW-1:0] adj;
      diff = CW'(t) - CW'(c.ext_clock_start_time) + nor_timing_pkg::DIFF_BIAS;
      case (c.ext_clock_divide_sel)
         nor_timing_pkg::DIV_BY_ONE: adj = nor_timing_pkg::CNT_ZERO;
         nor_timing_pkg::DIV_BY_TWO: adj = CW'(t[0] ^ c.ext_clock_start_time[0]);
         nor_timing_pkg::DIV_BY_THREE: adj = diff % 8'h03;
         default: adj = CW'(diff[1:0]);
      endcase
      place = scale(t, c.timing_scale_x2) + adj;
   endfunction
   // ==========================================================================
   // Request latch
   nor_timing_pkg::select_cfg_t cfg_sel;
   nor_timing_pkg::engine_state_t state_r;
   logic accept;
   logic [CW-1:0] page_nxt;
   logic [CW-1:0] burst_nxt;
   logic [CW-1:0] e_cs_on_r, e_cs_off_r, e_adv_on_r, e_adv_off_r, e_oe_on_r, e_oe_off_r;
   logic [CW-1:0] e_we_on_r, e_we_off_r, e_len_r, e_sample_r, e_page_r, e_gap_r;
   logic [nor_timing_pkg::PAGE_W-1:0] clk_start_r;
   logic [1:0] div_r;
   logic cs_half_r, adv_half_r, oe_half_r, we_half_r, wait_en_r, wait_sel_r, write_r;
   logic [nor_timing_pkg::SEL_W-1:0] sel_r;
   logic [nor_timing_pkg::ADDR_W-1:0] addr_r;
   logic [1:0] be_r;
   logic [nor_timing_pkg::DATA_W-1:0] wdata_r;
   logic [nor_timing_pkg::BURST_W-1:0] extra_r;
   assign cfg_sel = cfg_in[req_in.select];
   assign accept = req_valid_in && req_ready_out;
   assign page_nxt = scale(nor_timing_pkg::TIME_W'(cfg_sel.page_word_interval), cfg_sel.timing_scale_x2);
   assign burst_nxt = CW'(req_in.extra_words) * page_nxt;
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         {e_cs_on_r, e_cs_off_r, e_adv_on_r, e_adv_off_r, e_oe_on_r, e_oe_off_r} <= '0;
         {e_we_on_r, e_we_off_r, e_len_r, e_sample_r, e_page_r, e_gap_r} <= '0;
         {cs_half_r, adv_half_r, oe_half_r, we_half_r, wait_en_r, wait_sel_r, write_r} <= '0;
         clk_start_r <= '0;
         div_r <= nor_timing_pkg::DIV_BY_ONE;
         sel_r <= '0;
         addr_r <= '0;
         be_r <= '0;
         wdata_r <= '0;
         extra_r <= '0;
      end else if (accept) begin
         e_cs_on_r <= place(cfg_sel.select_assert_time, cfg_sel);
         e_cs_off_r <= place(req_in.write ? cfg_sel.select_write_release_time
                                          : cfg_sel.select_read_release_time, cfg_sel) + burst_nxt;
         e_adv_on_r <= place(cfg_sel.addr_valid_assert_time, cfg_sel);
         e_adv_off_r <= place(req_in.write ? cfg_sel.addr_valid_write_release
                                           : cfg_sel.addr_valid_read_release, cfg_sel);
         e_oe_on_r <= place(cfg_sel.read_strobe_assert_time, cfg_sel);
         e_oe_off_r <= place(cfg_sel.read_strobe_release_time, cfg_sel) + burst_nxt;
         e_we_on_r <= place(cfg_sel.write_strobe_assert_time, cfg_sel);
         e_we_off_r <= place(cfg_sel.write_strobe_release_time, cfg_sel);
         e_len_r <= scale(req_in.write ? cfg_sel.write_cycle_length
                                       : cfg_sel.read_cycle_length, cfg_sel.timing_scale_x2) + burst_nxt;
         e_sample_r <= scale(cfg_sel.sample_delay, cfg_sel.timing_scale_x2);
         e_page_r <= page_nxt;
         e_gap_r <= scale(nor_timing_pkg::TIME_W'(cfg_sel.inter_access_gap), cfg_sel.timing_scale_x2);
         clk_start_r <= cfg_sel.ext_clock_start_time;
         div_r <= cfg_sel.ext_clock_divide_sel;
         cs_half_r <= cfg_sel.select_half_cycle;
         adv_half_r <= cfg_sel.addr_valid_half_cycle;
         oe_half_r <= cfg_sel.read_strobe_half_cycle;
         we_half_r <= cfg_sel.write_strobe_half_cycle;
         wait_en_r <= cfg_sel.wait_enable;
         wait_sel_r <= cfg_sel.wait_pin_sel;
         write_r <= req_in.write;
         sel_r <= req_in.select;
         addr_r <= req_in.addr;
         be_r <= req_in.byte_en;
         wdata_r <= req_in.wdata;
         extra_r <= req_in.extra_words;
      end
   end
   // ==========================================================================
   // Sequencer
   logic act;
   logic stall;
   logic due;
   logic step;
   logic push;
   logic last;
   logic fifo_in_ready;
   logic [CW-1:0] cyc_r;
   logic [CW-1:0] gap_cnt_r;
   logic [CW-1:0] next_sample_r;
   logic [nor_timing_pkg::BURST_W:0] idx_r;
   logic cs_pos_r;
   assign act = state_r == nor_timing_pkg::ST_ACCESS;
   assign due = act && cyc_r == next_sample_r && idx_r <= {1'b0, extra_r};
   // A full read FIFO freezes the access just like a wait pin
   assign stall = (act && wait_en_r && wait_in[wait_sel_r] && cs_pos_r) || (due && !write_r && !fifo_in_ready);
   assign step = due && !stall;
   assign push = step && !write_r;
   assign last = (cyc_r + nor_timing_pkg::CNT_ONE) >= e_len_r;
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= nor_timing_pkg::ST_IDLE;
         gap_cnt_r <= nor_timing_pkg::CNT_ZERO;
         req_ready_out <= 1'b0;
      end else begin
         req_ready_out <= 1'b0;
         case (state_r)
            nor_timing_pkg::ST_IDLE: begin
               req_ready_out <= !accept;
               if (accept) begin
                  state_r <= nor_timing_pkg::ST_ACCESS;
               end
            end
            nor_timing_pkg::ST_ACCESS: begin
               if (!stall && last) begin
                  gap_cnt_r <= e_gap_r;
                  state_r <= (e_gap_r == nor_timing_pkg::CNT_ZERO) ? nor_timing_pkg::ST_IDLE
                                                                   : nor_timing_pkg::ST_GAP;
                  req_ready_out <= e_gap_r == nor_timing_pkg::CNT_ZERO;
               end
            end
            nor_timing_pkg::ST_GAP: begin
               gap_cnt_r <= gap_cnt_r - nor_timing_pkg::CNT_ONE;
               if (gap_cnt_r == nor_timing_pkg::CNT_ONE) begin
                  state_r <= nor_timing_pkg::ST_IDLE;
                  req_ready_out <= 1'b1;
               end
            end
            default: begin
               state_r <= nor_timing_pkg::ST_IDLE;
            end
         endcase
      end
   end
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         cyc_r <= nor_timing_pkg::CNT_ZERO;
         next_sample_r <= nor_timing_pkg::CNT_ZERO;
         idx_r <= nor_timing_pkg::IDX_ZERO;
      end else if (accept) begin
         cyc_r <= nor_timing_pkg::CNT_ZERO;
         next_sample_r <= scale(cfg_sel.sample_delay, cfg_sel.timing_scale_x2);
         idx_r <= nor_timing_pkg::IDX_ZERO;
      end else if (act && !stall) begin
         cyc_r <= cyc_r + nor_timing_pkg::CNT_ONE;
         if (step) begin
            next_sample_r <= next_sample_r + e_page_r;
            idx_r <= idx_r + 1'b1;
         end
      end
   end
   // ==========================================================================
   // Strobes on the rising edge
   logic adv_pos_r, oe_pos_r, we_pos_r;
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         cs_pos_r <= 1'b0;
         adv_pos_r <= 1'b0;
         oe_pos_r <= 1'b0;
         we_pos_r <= 1'b0;
         byte_en_n_out <= nor_timing_pkg::BYTES_OFF;
         addr_drive_out <= 1'b0;
         addr_out <= '0;
         data_out <= '0;
         data_oe_out <= 1'b0;
         busy_out <= 1'b0;
      end else begin
         cs_pos_r <= act && cyc_r >= e_cs_on_r && cyc_r < e_cs_off_r;
         adv_pos_r <= act && cyc_r >= e_adv_on_r && cyc_r < e_adv_off_r;
         oe_pos_r <= act && !write_r && cyc_r >= e_oe_on_r && cyc_r < e_oe_off_r;
         we_pos_r <= act && write_r && cyc_r >= e_we_on_r && cyc_r < e_we_off_r;
         byte_en_n_out <= act ? ~be_r : nor_timing_pkg::BYTES_OFF;
         addr_drive_out <= act;
         addr_out <= addr_r + nor_timing_pkg::ADDR_W'(idx_r);
         data_out <= wdata_r;
         data_oe_out <= act && write_r;
         busy_out <= !(state_r == nor_timing_pkg::ST_IDLE);
      end
   end
   // ==========================================================================
   // Half-cycle copies on the falling edge
   logic cs_neg_r, adv_neg_r, oe_neg_r, we_neg_r;
   logic cs_lvl;
   always_ff @(negedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         {cs_neg_r, adv_neg_r, oe_neg_r, we_neg_r} <= '0;
      end else begin
         {cs_neg_r, adv_neg_r, oe_neg_r, we_neg_r} <= {cs_pos_r, adv_pos_r, oe_pos_r, we_pos_r};
      end
   end
   assign cs_lvl = cs_half_r ? cs_neg_r : cs_pos_r;
   assign addr_valid_n_out = !(adv_half_r ? adv_neg_r : adv_pos_r);
   assign read_strobe_n_out = !(oe_half_r ? oe_neg_r : oe_pos_r);
   assign write_strobe_n_out = !(we_half_r ? we_neg_r : we_pos_r);
   genvar gi;
   generate
      for (gi = 0; gi < nor_timing_pkg::NUM_SELECTS; gi++) begin : g_select
         assign cs_n_out[gi] = !(cs_lvl && sel_r == nor_timing_pkg::SEL_W'(gi));
      end
   endgenerate
   // ==========================================================================
   // External memory clock
   logic [1:0] phase_r;
   logic running;
   logic [1:0] hi_len;
   assign running = act && cyc_r >= CW'(clk_start_r);
   assign hi_len = 2'((3'(div_r) + 3'h2) >> 1);
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         phase_r <= 2'h0;
         ext_clk_out <= 1'b0;
      end else begin
         phase_r <= (!running || phase_r == div_r) ? 2'h0 : phase_r + 2'h1;
         ext_clk_out <= running && phase_r < hi_len;
      end
   end
   // ==========================================================================
   // Read data buffer
   word_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_read_fifo (
      .clk_in(mclk_in),
      .rst_n_in(rst_n),
      .in_valid_in(push),
      .in_data_in(FIFO_WIDTH'(data_in)),
      .in_ready_out(fifo_in_ready),
      .out_valid_out(rd_valid_out),
      .out_data_out(rd_data_out),
      .out_ready_in(rd_ready_in)
   );
   // ==========================================================================
   // Checks
   logic [CW-1:0] inv_cnt_r;
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         inv_cnt_r <= nor_timing_pkg::CNT_MAX;
      end else if (addr_drive_out) begin
         inv_cnt_r <= nor_timing_pkg::CNT_ZERO;
      end else if (inv_cnt_r != nor_timing_pkg::CNT_MAX) begin
         inv_cnt_r <= inv_cnt_r + nor_timing_pkg::CNT_ONE;
      end
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n);
   chk_cs_one_low: assert property ($onehot0(~cs_n_out))
      else $error("more than one chip select low");
   chk_cs_assert_at: assert property (act && !stall && cyc_r == e_cs_on_r && e_cs_on_r < e_cs_off_r |=> cs_pos_r)
      else $error("chip select not asserted at its time");
   chk_cs_release_at: assert property (act && cyc_r == e_cs_off_r |=> !cs_pos_r)
      else $error("chip select held past release time");
   chk_sample_slot: assert property (push |-> cyc_r == CW'(e_sample_r + CW'(idx_r) * e_page_r))
      else $error("read data sampled at wrong cycle");
   chk_oe_release: assert property ($fell(oe_pos_r) |-> $past(cyc_r) == e_oe_off_r || !$past(act) || $past(last))
      else $error("read strobe released at wrong cycle");
   chk_gap_min: assert property ($rose(addr_drive_out) |-> inv_cnt_r >= $past(e_gap_r, 2))
      else $error("address invalid gap too short");
   chk_stall_freeze: assert property (act && stall |=> $stable(cyc_r) && $stable(idx_r))
      else $error("access advanced during stall");
   chk_phase_range: assert property (phase_r <= div_r)
      else $error("external clock phase out of range");
   chk_be_span: assert property (byte_en_n_out != nor_timing_pkg::BYTES_OFF |-> addr_drive_out)
      else $error("byte enables active outside access");
   chk_we_reads: assert property (we_pos_r |-> write_r && !oe_pos_r)
      else $error("write strobe during read");
   chk_access_end: assert property (act && !stall && last |=> !act)
      else $error("access longer than cycle length");
   cov_burst_read: cover property (push && idx_r == 3'h3);
   cov_write_done: cover property (act && write_r && last ##1 state_r == nor_timing_pkg::ST_GAP);
   cov_wait_stall: cover property (act && stall && wait_en_r);
   cov_fifo_full: cover property (due && !write_r && !fifo_in_ready);
endmodule
`default_nettype wire

//--- logic/nor_timing_pkg.sv
// Shared constants and types of the asynchronous NOR strobe timing engine
package nor_timing_pkg;
   // ==========================================================================
   // Sizes
   localparam int NUM_SELECTS = 8;
   localparam int NUM_WAITS = 2;
   localparam int TIME_W = 5;
   localparam int PAGE_W = 4;
   localparam int CNT_W = 8;
   localparam int ADDR_W = 27;
   localparam int DATA_W = 16;
   localparam int BURST_W = 2;
   localparam int SEL_W = 3;
   localparam int FIFO_DEPTH = 4;
   // ==========================================================================
   // External clock divider codes
   localparam logic [1:0] DIV_BY_ONE = 2'h0;
   localparam logic [1:0] DIV_BY_TWO = 2'h1;
   localparam logic [1:0] DIV_BY_THREE = 2'h2;
   // Keeps edge minus start time positive; a multiple of both 3 and 4
   localparam logic [CNT_W-1:0] DIFF_BIAS = 8'h18;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
   localparam logic [BURST_W:0] IDX_ZERO = 3'h0;
   localparam logic [1:0] BYTES_OFF = 2'h3;
   // ==========================================================================
   // Per chip select timing set
   typedef struct packed {
      logic [1:0] ext_clock_divide_sel;
      logic timing_scale_x2;
      logic [TIME_W-1:0] select_assert_time;
      logic [TIME_W-1:0] select_read_release_time;
      logic [TIME_W-1:0] select_write_release_time;
      logic [TIME_W-1:0] addr_valid_assert_time;
      logic [TIME_W-1:0] addr_valid_read_release;
      logic [TIME_W-1:0] addr_valid_write_release;
      logic [TIME_W-1:0] read_strobe_assert_time;
      logic [TIME_W-1:0] read_strobe_release_time;
      logic [TIME_W-1:0] write_strobe_assert_time;
      logic [TIME_W-1:0] write_strobe_release_time;
      logic [TIME_W-1:0] read_cycle_length;
      logic [TIME_W-1:0] write_cycle_length;
      logic [TIME_W-1:0] sample_delay;
      logic [PAGE_W-1:0] page_word_interval;
      logic [PAGE_W-1:0] inter_access_gap;
      logic [PAGE_W-1:0] ext_clock_start_time;
      logic select_half_cycle;
      logic addr_valid_half_cycle;
      logic read_strobe_half_cycle;
      logic write_strobe_half_cycle;
      logic wait_enable;
      logic wait_pin_sel;
   } select_cfg_t;
   typedef struct packed {
      logic write;
      logic [SEL_W-1:0] select;
      logic [ADDR_W-1:0] addr;
      logic [1:0] byte_en;
      logic [DATA_W-1:0] wdata;
      logic [BURST_W-1:0] extra_words;
   } access_req_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ACCESS = 3'b010,
      ST_GAP = 3'b100
   } engine_state_t;
endpackage

//--- logic/word_fifo.sv
// Read data FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in
);
   // Depth is a power of two so the pointers wrap on their own
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;
   assign in_ready_out = count_r != (AW+1)'(DEPTH);
   assign out_valid_out = count_r != '0;
   assign out_data_out = mem_r[rd_ptr_r];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_in;
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

//--- tb/nor_mem_model.sv
// Behavioural parallel NOR memory answering reads from its address lines
`timescale 1ns/10ps
`default_nettype none
module nor_mem_model (
   input wire logic read_strobe_n_in,
   input wire logic [7:0] cs_n_in,
   input wire logic [26:0] addr_in,
   output logic [15:0] data_out
);
   // Released bus shows the inverse pattern, never the last word
   always_comb begin
      if (read_strobe_n_in == 1'b0 && cs_n_in != 8'hff) begin
         data_out = addr_in[15:0] ^ 16'h5a3c;
      end else begin
         data_out = ~(addr_in[15:0] ^ 16'h5a3c);
      end
   end
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench: random single and page accesses on all chip selects
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic mclk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic req_valid_in = 1'b0;
   logic rd_ready_in = 1'b0;
   logic [1:0] wait_in = 2'h0;
   nor_timing_pkg::access_req_t req_in = '0;
   nor_timing_pkg::select_cfg_t cfg_in [nor_timing_pkg::NUM_SELECTS];
   logic req_ready_out, addr_valid_n_out, read_strobe_n_out, write_strobe_n_out;
   logic addr_drive_out, data_oe_out, ext_clk_out, busy_out, rd_valid_out;
   logic [7:0] cs_n_out;
   logic [1:0] byte_en_n_out;
   logic [26:0] addr_out;
   logic [15:0] data_out, data_in, rd_data_out;
   logic [15:0] exp_q [$];
   int failures = 0;
   int n_tests = 0;
   async_nor_flash_timing_engine async_nor_flash_timing_engine_i (.mclk_in, .arst_n_in, .req_valid_in,
      .req_in, .req_ready_out, .cfg_in, .wait_in, .cs_n_out, .addr_valid_n_out, .read_strobe_n_out,
      .write_strobe_n_out, .byte_en_n_out, .addr_out, .addr_drive_out, .data_out, .data_oe_out, .data_in,
      .ext_clk_out, .busy_out, .rd_valid_out, .rd_data_out, .rd_ready_in);
   nor_mem_model nor_mem_model_i (.read_strobe_n_in(read_strobe_n_out), .cs_n_in(cs_n_out),
      .addr_in(addr_out), .data_out(data_in));
   always #20 mclk_in = ~mclk_in;
   // ==========================================================
   // Checking helpers
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Edge cycle of a time field: scaled, then lined up with the external clock phase
   function automatic int aligned(input int t, input int sc, input int dv, input int st);
      int m;
      m = dv + 1;
      return t * (sc + 1) + ((dv == 0) ? 0 : (((t - st) % m) + m) % m);
   endfunction
   function automatic int win(input int a, input int b);
      return (b > a) ? b - a : 0;
   endfunction
   function automatic nor_timing_pkg::select_cfg_t mk_cfg(input logic sc);
      nor_timing_pkg::select_cfg_t c;
      c = '0;
      c.timing_scale_x2 = sc;
      c.select_assert_time = 5'h01;
      c.select_read_release_time = 5'h06;
      c.select_write_release_time = 5'h06;
      c.addr_valid_assert_time = 5'h01;
      c.addr_valid_read_release = 5'h04;
      c.addr_valid_write_release = 5'h05;
      c.read_strobe_assert_time = 5'h02;
      c.read_strobe_release_time = 5'h06;
      c.write_strobe_assert_time = 5'h02;
      c.write_strobe_release_time = 5'h05;
      c.read_cycle_length = 5'h08;
      c.write_cycle_length = 5'h08;
      c.sample_delay = 5'h05;
      c.page_word_interval = 4'h2;
      c.inter_access_gap = 4'h2;
      return c;
   endfunction
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ==========================================================
   // One access; counts strobe cycles at settled falling edges
   task automatic run_access(input logic wr, input logic [2:0] sel, input logic sc, input logic [1:0] xw);
      int k, cs_cnt, oe_cnt, we_cnt, av_cnt, ad_cnt, ck_cnt, gp_cnt, bad, dv, st, wt, bu, n, p, h;
      logic [26:0] a;
      logic w;
      a = 27'($urandom);
      // Divider codes only with doubled scale, wait stalls only with divide-by-one
      dv = sc ? $urandom_range(3) : 0;
      wt = sc ? 0 : $urandom_range(3);
      st = $urandom_range(15);
      cs_cnt = 0;
      oe_cnt = 0;
      we_cnt = 0;
      av_cnt = 0;
      ad_cnt = 0;
      ck_cnt = 0;
      gp_cnt = 0;
      bad = 0;
      cfg_in[sel] = mk_cfg(sc);
      cfg_in[sel].ext_clock_divide_sel = 2'(dv);
      cfg_in[sel].ext_clock_start_time = 4'(st);
      cfg_in[sel].wait_enable = 1'b1;
      cfg_in[sel].wait_pin_sel = sel[0];
      req_in = '{write: wr, select: sel, addr: a, byte_en: 2'($urandom), wdata: 16'($urandom), extra_words: xw};
      for (k = 0; k <= xw && !wr; k++) exp_q.push_back(16'(a + 27'(k)) ^ 16'h5a3c);
      req_valid_in = 1'b1;
      k = 0;
      while (req_ready_out !== 1'b1 && k < 200) begin
         @(negedge mclk_in);
         k++;
      end
      @(negedge mclk_in);
      req_valid_in = 1'b0;
      k = 0;
      do begin
         @(negedge mclk_in);
         k++;
         cs_cnt += int'(cs_n_out[sel] === 1'b0);
         oe_cnt += int'(read_strobe_n_out === 1'b0);
         we_cnt += int'(write_strobe_n_out === 1'b0);
         bad += int'((cs_n_out | (8'h01 << sel)) !== 8'hff);
         bad += int'(write_strobe_n_out === 1'b0 && data_out !== req_in.wdata);
         av_cnt += int'(addr_valid_n_out === 1'b0);
         ad_cnt += int'(addr_drive_out === 1'b1);
         ck_cnt += int'(ext_clk_out === 1'b1);
         gp_cnt += int'(addr_drive_out === 1'b0 && ad_cnt > 0);
         bad += int'(byte_en_n_out !== (addr_drive_out === 1'b1 ? ~req_in.byte_en : 2'h3));
         bad += int'(data_oe_out !== (addr_drive_out === 1'b1 && wr));
         bad += int'(addr_drive_out === 1'b1 && busy_out !== 1'b1);
         // Selected wait pin freezes the access for wt edges; the other pin carries noise
         w = cs_cnt >= 2 && cs_cnt < 2 + wt;
         wait_in = sel[0] ? {w, 1'($urandom)} : {1'($urandom), w};
      end while (!(req_ready_out === 1'b1 && cs_cnt > 0) && k < 200);
      wait_in = 2'h0;
      bu = 2 * xw * (sc + 1);
      n = (8 + 2 * xw) * (sc + 1) - st;
      n = n > 0 ? n : 0;
      p = dv + 1;
      h = (p + 1) / 2;
      cmp(cs_cnt, win(aligned(1, sc, dv, st), aligned(6, sc, dv, st) + bu) + wt);
      cmp(oe_cnt, wr ? 0 : win(aligned(2, sc, dv, st), aligned(6, sc, dv, st) + bu) + wt);
      cmp(we_cnt, wr ? win(aligned(2, sc, dv, st), aligned(5, sc, dv, st)) + wt : 0);
      cmp(av_cnt, win(aligned(1, sc, dv, st), aligned(wr ? 5 : 4, sc, dv, st)) + wt);
      cmp(ad_cnt, (8 + 2 * xw) * (sc + 1) + wt);
      cmp(gp_cnt, 2 * (sc + 1));
      cmp(ck_cnt, (n / p) * h + (n % p < h ? n % p : h) + (st <= 3 ? wt : 0));
      cmp(bad, 0);
      k = 0;
      while (exp_q.size() > 0 && k < 100) begin
         @(negedge mclk_in);
         k++;
      end
      cmp(exp_q.size(), 0);
   endtask
   always @(negedge mclk_in) rd_ready_in <= 1'($urandom);
   always @(posedge mclk_in) begin
      if (rd_valid_out === 1'b1 && rd_ready_in === 1'b1) begin
         cmp(32'(rd_data_out), exp_q.size() > 0 ? 32'(exp_q.pop_front()) : 32'hdead);
      end
   end
   initial begin
      for (int i = 0; i < 8; i++) cfg_in[i] = mk_cfg(1'b0);
      void'($urandom(80766));
      repeat (16) @(posedge mclk_in);
      @(negedge mclk_in);
      arst_n_in = 1'b1;
      repeat (4) @(negedge mclk_in);
      for (int t = 0; t < 24; t++) begin
         run_access(1'($urandom), 3'(t), 1'(t >> 3), 2'($urandom));
         $display("test %0d done", t);
      end
      run_access(1'b0, 3'h7, 1'b1, 2'h3);
      tally_and_finish;
   end
   initial begin
      #2000000;
      failures++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
